// ### rtl/occ_ctrl_regs.svh
// register map, field positions and counts for the oscillator control block
`ifndef OCC_CTRL_REGS_SVH
`define OCC_CTRL_REGS_SVH

`define OCC_ADR_W 4
`define OCC_CTRL_OFS 4'h0
`define OCC_CFG_OFS 4'h4
`define OCC_RST_VAL 8'h00
`define OCC_CTRL_WMASK 8'hD1
`define OCC_CFG_WMASK 8'hE3
`define OCC_EN_BIT 7
`define OCC_OE_BIT 6
`define OCC_LVL_BIT 5
`define OCC_POL_BIT 4
`define OCC_PFM_BIT 0
`define OCC_PWS_HI 7
`define OCC_PWS_LO 5
`define OCC_CKS_HI 1
`define OCC_CKS_LO 0
`define OCC_PCNT_W 7

`endif

// ### rtl/occ_pkg.sv
// types shared by the oscillator control modules
package occ_pkg;
  // order matches the clock source field encoding
  typedef enum logic [1:0] {
    CS_HF_INTERNAL,
    CS_SYSTEM,
    CS_LOGIC_CELL1,
    CS_EXT_PIN
  } occ_clk_src_e;
  typedef enum logic {PS_LOW, PS_HIGH} occ_pstate_e;
  typedef enum logic {BUS_IDLE, BUS_ACK} occ_bus_e;
endpackage

// ### rtl/occ_pulse_if.sv
// carrier between the control core and the output pulse generator
`timescale 1ns/100ps
`default_nettype none
interface occ_pulse_if;
  logic tick;
  logic ovf;
  logic en;
  logic pfm;
  logic [2:0] pws;
  logic out;
  modport gen (input tick, input ovf, input en, input pfm, input pws,
    output out);
  modport ctl (output tick, output ovf, output en, output pfm,
    output pws, input out);
endinterface
`default_nettype wire

// ### rtl/occ_pulse.sv
// output waveform generator: toggle or fixed-width pulse per overflow
`timescale 1ns/100ps
`default_nettype none
`include "occ_ctrl_regs.svh"
module occ_pulse
  import occ_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  occ_pulse_if.gen pif
);
  occ_pstate_e state_reg;
  logic [`OCC_PCNT_W-1:0] cnt_reg;
  logic [`OCC_PCNT_W-1:0] last_cnt;
  logic [7:0] hp_cnt_reg;

  // terminal count is two to the field, minus one
  assign last_cnt = `OCC_PCNT_W'((8'h01 << pif.pws) - 8'h01);

  // overflow beats a tick in the same cycle so a new pulse always restarts
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= PS_LOW;
      cnt_reg <= '0;
    end else if (!pif.en) begin
      state_reg <= PS_LOW;
      cnt_reg <= '0;
    end else if (!pif.pfm) begin
      cnt_reg <= '0; // width ignored here
      if (pif.ovf) begin
        state_reg <= (state_reg == PS_LOW) ? PS_HIGH : PS_LOW;
      end
    end else begin
      case (state_reg)
        PS_LOW: begin
          if (pif.ovf) begin
            state_reg <= PS_HIGH;
            cnt_reg <= '0;
          end
        end
        PS_HIGH: begin
          if (pif.ovf) begin
            cnt_reg <= '0;
          end else if (pif.tick) begin
            if (cnt_reg == last_cnt) begin
              state_reg <= PS_LOW;
            end else begin
              cnt_reg <= cnt_reg + `OCC_PCNT_W'(1);
            end
          end
        end
        default: state_reg <= PS_LOW;
      endcase
    end
  end

  assign pif.out = (state_reg == PS_HIGH);

  // helper: source periods seen during the current high phase
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hp_cnt_reg <= 8'h00;
    end else if (pif.ovf || state_reg == PS_LOW) begin
      hp_cnt_reg <= 8'h00;
    end else if (pif.tick) begin
      hp_cnt_reg <= hp_cnt_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_pulse_width;
    ($fell(pif.out) && pif.en && $past(pif.en) && $past(pif.pfm) &&
      $stable(pif.pws)) |-> (hp_cnt_reg == (8'h01 << pif.pws));
  endproperty
  a_pulse_width: assert property (p_pulse_width)
    else $error("pulse width differs from selected count");

  property p_fdc_toggle;
    (pif.en && !pif.pfm && pif.ovf) |=> (pif.out != $past(pif.out));
  endproperty
  a_fdc_toggle: assert property (p_fdc_toggle)
    else $error("fixed duty output did not toggle on overflow");

  property p_fdc_hold;
    (pif.en && !pif.pfm && !pif.ovf) |=> $stable(pif.out);
  endproperty
  a_fdc_hold: assert property (p_fdc_hold)
    else $error("fixed duty output moved without overflow");
endmodule
`default_nettype wire

// ### rtl/occ_ctrl.sv
// oscillator control: wishbone registers, clock select, output and pin
`timescale 1ns/100ps
`default_nettype none
`include "occ_ctrl_regs.svh"
module occ_ctrl
  import occ_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`OCC_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic internal_hf_oscillator,
  input wire logic system_osc_clock,
  input wire logic logic_cell1_output,
  input wire logic external_osc_clock_pin,
  input wire logic accumulator_overflow,
  output logic osc_clock_tick,
  output logic accumulator_enable,
  output logic osc_output_signal,
  output logic osc_pin_out,
  output logic osc_pin_oe_n
);

  // register state
  logic [7:0] ctrl_reg;
  logic [7:0] cfg_reg;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  occ_bus_e bus_reg;

  // decoded controls
  logic osc_module_enable;
  logic osc_pin_enable;
  logic osc_polarity;
  logic pulse_freq_mode_select;
  logic [2:0] pulse_width_select;
  logic [1:0] osc_clock_source_select;

  // bus decode
  logic bus_req;
  logic bus_take;
  logic [`OCC_ADR_W-1:0] word_adr;
  logic hit_ctrl;
  logic hit_cfg;
  logic wr_low;

  // clock source path
  logic ext_s1_reg;
  logic ext_s2_reg;
  logic ext_s3_reg;
  logic ext_lvl_reg;
  logic [3:0] src_lvl;
  logic [3:0] src_prev_reg;
  logic [3:0] src_rise;
  logic tick_reg;

  // output path
  logic out_sig_reg;
  logic pin_out_reg;
  logic pin_oe_n_reg;
  logic pin_drive;

  occ_pulse_if pif ();

  // field views of the two registers
  assign osc_module_enable = ctrl_reg[`OCC_EN_BIT];
  assign osc_pin_enable = ctrl_reg[`OCC_OE_BIT];
  assign osc_polarity = ctrl_reg[`OCC_POL_BIT];
  assign pulse_freq_mode_select = ctrl_reg[`OCC_PFM_BIT];
  assign pulse_width_select = cfg_reg[`OCC_PWS_HI:`OCC_PWS_LO];
  assign osc_clock_source_select = cfg_reg[`OCC_CKS_HI:`OCC_CKS_LO];

  // one request per handshake; low two address bits are byte offsets
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_take = bus_req && (bus_reg == BUS_IDLE);
  assign word_adr = {wb_adr_i[`OCC_ADR_W-1:2], 2'b00};
  assign wr_low = bus_take && wb_we_i && wb_sel_i[0];

  // address decode
  always_comb begin
    hit_ctrl = 1'b0;
    hit_cfg = 1'b0;
    if (word_adr == `OCC_CTRL_OFS) begin
      hit_ctrl = 1'b1;
    end else if (word_adr == `OCC_CFG_OFS) begin
      hit_cfg = 1'b1;
    end
  end

  // ack follows the taken request by one edge and then drops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bus_reg <= BUS_IDLE;
    end else begin
      case (bus_reg)
        BUS_IDLE: begin
          if (bus_req) begin
            bus_reg <= BUS_ACK;
          end
        end
        BUS_ACK: bus_reg <= BUS_IDLE;
        default: bus_reg <= BUS_IDLE;
      endcase
    end
  end

  assign wb_ack_o = (bus_reg == BUS_ACK);

  // control register: output level bit is not stored, only read live
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_reg <= `OCC_RST_VAL;
    end else if (wr_low && hit_ctrl) begin
      ctrl_reg <= wb_dat_i[7:0] & `OCC_CTRL_WMASK;
    end
  end

  // clock and pulse-width register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= `OCC_RST_VAL;
    end else if (wr_low && hit_cfg) begin
      cfg_reg <= wb_dat_i[7:0] & `OCC_CFG_WMASK;
    end
  end

  // read mux; unmapped words read zero and are still acknowledged
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_ctrl) begin
      rdata_next[7:0] = ctrl_reg & `OCC_CTRL_WMASK;
      rdata_next[`OCC_LVL_BIT] = out_sig_reg;
    end else if (hit_cfg) begin
      rdata_next[7:0] = cfg_reg & `OCC_CFG_WMASK;
    end
  end

  // read data captured at the taking edge, shown with ack
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_take && !wb_we_i) begin
      rdata_reg <= rdata_next;
    end
  end

  assign wb_dat_o = rdata_reg;

  // external pin crosses in: first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= external_osc_clock_pin;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  // level accepted only once two late stages agree, which eats glitches
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_lvl_reg <= 1'b0;
    end else if (ext_s2_reg == ext_s3_reg) begin
      ext_lvl_reg <= ext_s3_reg;
    end
  end

  // index order follows the clock source encoding
  assign src_lvl = {ext_lvl_reg, logic_cell1_output, system_osc_clock,
    internal_hf_oscillator};

  // rising edge of each candidate source, one enable pulse per period;
  // sources faster than half of clk lose edges, a known limitation
  generate
    for (genvar g = 0; g < 4; g++) begin : g_src
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          src_prev_reg[g] <= 1'b0;
        end else begin
          src_prev_reg[g] <= src_lvl[g];
        end
      end
      assign src_rise[g] = src_lvl[g] && !src_prev_reg[g];
    end
  endgenerate

  // selected source tick, gated off while the module is disabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= osc_module_enable && src_rise[osc_clock_source_select];
    end
  end

  assign osc_clock_tick = tick_reg;
  assign accumulator_enable = osc_module_enable;

  // hand the controls to the waveform generator
  assign pif.tick = tick_reg;
  assign pif.ovf = accumulator_overflow && osc_module_enable;
  assign pif.en = osc_module_enable;
  assign pif.pfm = pulse_freq_mode_select;
  assign pif.pws = pulse_width_select;

  occ_pulse u_pulse (
    .clk(clk),
    .arst_n(arst_n),
    .pif(pif)
  );

  // polarity applied once, ahead of both the status bit and the pin
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sig_reg <= 1'b0;
    end else begin
      out_sig_reg <= pif.out ^ osc_polarity;
    end
  end

  assign osc_output_signal = out_sig_reg;
  assign pin_drive = osc_module_enable && osc_pin_enable;

  // pin driven only when both enables are set; idle pin level is low
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_out_reg <= 1'b0;
      pin_oe_n_reg <= 1'b1;
    end else begin
      pin_out_reg <= pin_drive ? out_sig_reg : 1'b0;
      pin_oe_n_reg <= !pin_drive;
    end
  end

  assign osc_pin_out = pin_out_reg;
  assign osc_pin_oe_n = pin_oe_n_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  property p_no_tick_off;
    !osc_module_enable |=> !osc_clock_tick;
  endproperty
  a_no_tick_off: assert property (p_no_tick_off)
    else $error("tick issued while module disabled");

  property p_pin_follows;
    ##1 $changed(pin_drive) |=> (osc_pin_oe_n == !$past(pin_drive));
  endproperty
  a_pin_follows: assert property (p_pin_follows)
    else $error("pin enable did not follow the controls");

  property p_pin_gated;
    !osc_pin_oe_n |-> $past(osc_module_enable) && $past(osc_pin_enable);
  endproperty
  a_pin_gated: assert property (p_pin_gated)
    else $error("pin driven without both enables");

  property p_level_read;
    (bus_take && !wb_we_i && hit_ctrl) |=>
      (wb_ack_o && wb_dat_o[`OCC_LVL_BIT] == $past(out_sig_reg));
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("output level bit disagrees with output");

  // pin lags the generator by two edges, so polarity is taken from then
  property p_polarity;
    !osc_pin_oe_n |->
      (osc_pin_out == ($past(pif.out, 2) ^ $past(osc_polarity, 2)));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("pin level does not reflect polarity");

  property p_src_ext;
    (osc_module_enable && osc_clock_source_select == 2'(CS_EXT_PIN) &&
      $rose(ext_lvl_reg)) |=> osc_clock_tick;
  endproperty
  a_src_ext: assert property (p_src_ext)
    else $error("external pin edge gave no tick");

  property p_src_hf;
    (osc_module_enable && osc_clock_source_select == 2'(CS_HF_INTERNAL)
      && !src_rise[0]) |=> !osc_clock_tick;
  endproperty
  a_src_hf: assert property (p_src_hf)
    else $error("tick without edge of selected source");

  property p_reserved_zero;
    (bus_take && !wb_we_i) |=>
      (wb_dat_o[31:8] == 24'h000000 &&
       ($past(hit_ctrl) -> wb_dat_o[3:1] == 3'h0) &&
       ($past(hit_cfg) -> wb_dat_o[4:2] == 3'h0));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("unused bits read nonzero");

  property p_ack_one;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack held longer than one cycle");

  property p_ack_after_take;
    bus_take |=> wb_ack_o;
  endproperty
  a_ack_after_take: assert property (p_ack_after_take)
    else $error("taken request not acknowledged next cycle");

  // written fields appear in the register on the taking edge
  property p_ctrl_write;
    (wr_low && hit_ctrl) |=>
      (osc_module_enable == $past(wb_dat_i[`OCC_EN_BIT]) &&
       osc_polarity == $past(wb_dat_i[`OCC_POL_BIT]));
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not land");

  property p_cfg_write;
    (wr_low && hit_cfg) |=>
      (pulse_width_select == $past(wb_dat_i[`OCC_PWS_HI:`OCC_PWS_LO]) &&
       osc_clock_source_select == $past(wb_dat_i[`OCC_CKS_HI:`OCC_CKS_LO]));
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("clock register write did not land");

  // a released pin never shows a stale high
  property p_pin_idle;
    osc_pin_oe_n |-> !osc_pin_out;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("pin data high while released");

  property p_out_polarity;
    osc_module_enable |=>
      (osc_output_signal == ($past(pif.out) ^ $past(osc_polarity)));
  endproperty
  a_out_polarity: assert property (p_out_polarity)
    else $error("output does not follow generator and polarity");

  property p_src_sys;
    (osc_module_enable && osc_clock_source_select == 2'(CS_SYSTEM) &&
      src_rise[1]) |=> osc_clock_tick;
  endproperty
  a_src_sys: assert property (p_src_sys)
    else $error("system source edge gave no tick");
endmodule
`default_nettype wire

// ### sim/occ_ctrl_test.sv
// self-checking bench for the oscillator control block
`timescale 1ns/100ps
`default_nettype none
`include "occ_ctrl_regs.svh"
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module occ_ctrl_test import occ_pkg::*; ;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic hf_src = 1'b0;
  logic sys_src = 1'b0;
  logic lc_src = 1'b0;
  logic ext_src = 1'b0;
  logic ovf = 1'b0;
  logic tick;
  logic acc_en;
  logic out_sig;
  logic pin_out;
  logic pin_oe_n;
  int src_n = 0;
  int tick_n = 0;
  int high_n = 0;
  int cycles = 0;
  int compares = 0;
  int fail_count = 0;
  int d;
  int n;
  int exp_ticks [4] = '{30, 20, 15, 12};

  occ_ctrl u_occ_ctrl (
    .clk(clk),
    .arst_n(arst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .internal_hf_oscillator(hf_src),
    .system_osc_clock(sys_src),
    .logic_cell1_output(lc_src),
    .external_osc_clock_pin(ext_src),
    .accumulator_overflow(ovf),
    .osc_clock_tick(tick),
    .accumulator_enable(acc_en),
    .osc_output_signal(out_sig),
    .osc_pin_out(pin_out),
    .osc_pin_oe_n(pin_oe_n)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // distinct source periods (4, 6, 8, 10) so each select shows its own rate
  always @(posedge clk) begin
    src_n <= src_n + 1;
    hf_src <= (src_n % 4) < 2;
    sys_src <= (src_n % 6) < 3;
    lc_src <= (src_n % 8) < 4;
    ext_src <= (src_n % 10) < 5;
    if (tick === 1'b1) tick_n <= tick_n + 1;
    if (out_sig === 1'b1) high_n <= high_n + 1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      final_report();
    end
  end

  task final_report();
    $display("comparisons %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // one classic cycle; values read right after the edge are pre-edge samples
  task automatic wb_cycle(input logic [3:0] a, input logic w,
      input logic [7:0] v, output logic [31:0] q);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, v};
    // no local limit: only the bench timeout ends a stalled wait
    do begin
      @(posedge clk);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    `CHK(wb_ack_o, 1'b1)
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic [31:0] q;
    wb_cycle(a, 1'b1, v, q);
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb_cycle(a, 1'b0, 8'h00, q);
    `CHK(q, 32'(e))
  endtask

  task automatic wait_n(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic pulse_ovf();
    @(posedge clk);
    ovf <= 1'b1;
    @(posedge clk);
    ovf <= 1'b0;
  endtask

  initial begin
    wait_n(10);
    arst_n <= 1'b1;
    `CHK(pin_oe_n, 1'b1)
    `CHK(acc_en, 1'b0)
    rd_chk(`OCC_CTRL_OFS, 8'h00);
    rd_chk(`OCC_CFG_OFS, 8'h00);
    // all ones: reserved bits drop, level bit shows inverted idle output
    wr(`OCC_CTRL_OFS, 8'hFF);
    wait_n(4);
    rd_chk(`OCC_CTRL_OFS, 8'hF1);
    `CHK(acc_en, 1'b1)
    `CHK(pin_oe_n, 1'b0)
    `CHK(pin_out, 1'b1)
    wr(`OCC_CFG_OFS, 8'hFF);
    rd_chk(`OCC_CFG_OFS, 8'hE3);
    wr(4'h8, 8'hFF);
    rd_chk(4'h8, 8'h00);
    // each source select counts its own source's rising edges
    wr(`OCC_CTRL_OFS, 8'h80);
    for (int k = 0; k < 4; k++) begin
      wr(`OCC_CFG_OFS, k[7:0]);
      wait_n(10);
      n = tick_n;
      wait_n(120);
      d = tick_n - n;
      `CHK(d >= exp_ticks[k] - 1 && d <= exp_ticks[k] + 1, 1'b1)
    end
    // disabled: no ticks, overflow ignored
    wr(`OCC_CTRL_OFS, 8'h00);
    wait_n(4);
    n = tick_n;
    wait_n(40);
    `CHK(tick_n - n, 0)
    pulse_ovf();
    wait_n(4);
    `CHK(out_sig, 1'b0)
    `CHK(acc_en, 1'b0)
    // fixed duty: width field ignored, output toggles per overflow
    wr(`OCC_CFG_OFS, 8'h00);
    wr(`OCC_CTRL_OFS, 8'hC0);
    pulse_ovf();
    wait_n(20);
    `CHK(out_sig, 1'b1)
    `CHK(pin_out, 1'b1)
    rd_chk(`OCC_CTRL_OFS, 8'hE0);
    pulse_ovf();
    wait_n(5);
    `CHK(out_sig, 1'b0)
    `CHK(pin_out, 1'b0)
    // pin stays released unless both enables are set
    wr(`OCC_CTRL_OFS, 8'h40);
    wait_n(4);
    `CHK(pin_oe_n, 1'b1)
    `CHK(pin_out, 1'b0)
    wr(`OCC_CTRL_OFS, 8'h90);
    wait_n(4);
    `CHK(pin_oe_n, 1'b1)
    `CHK(out_sig, 1'b1)
    rd_chk(`OCC_CTRL_OFS, 8'hB0);
    // pulse mode: high time is two-to-the-field source periods of 4 cycles
    wr(`OCC_CTRL_OFS, 8'hC1);
    for (int w = 0; w < 8; w += 3) begin
      wr(`OCC_CFG_OFS, 8'(w << 5));
      n = high_n;
      pulse_ovf(); // one overflow per pulse keeps width in period
      wait_n((4 << w) + 20);
      d = high_n - n;
      n = 4 << w;
      `CHK(d >= n - 4 && d <= n + 1, 1'b1)
    end
    final_report();
  end
endmodule
`default_nettype wire
